// ==== pmr_top.sv ====
`timescale 1ns/1ps
`include "pmr_defines.svh"
// Functional notes
// - core_rail code 0.7V to 1.475V, 25mV steps
// - core_rail code is 1.3V after reset
// - forced pwm select chooses pwm or skip
// - separate variant: pll_ldo_enable drives pll_rail
// - separate variant: sram_ldo_enable drives sram_rail
// - combined variant: one enable drives both rails
// - sim_rail level one of four values
// - sim_rail level is 0V at power-up
// - sim_ldo_enable drives sim_rail
// - keepalive from io_rail, else backup battery
// - undervoltage lockout disables device, ignores enable inputs and core, sim and serial byte writes
// - written settings survive while supply adequate
// - reset low on manual reset or keepalive low
// - 65ms release delay when input above 2.4V; none if the reset condition ends in the input's first cycle above it
// - unpowered timer releases reset immediately
// - manual reset holds reset, restores core code
// - reset watches keepalive rail only
// - reset pin floats without backup battery
// - dead battery flag at dead threshold
// - low battery flag at low threshold
// - battery flags float without backup battery
// - sleep select steers enables to sleep regulators
// - serial byte bit5 selects core or sim
// - core, sim and serial byte writes only when enabled, above lockout; variant select written any time
module pmr_top import pmr_pkg::*; #(
    parameter int unsigned RST_DELAY_CYC = `PMR_RST_DELAY_NS / `PMR_CLK_PERIOD_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic manual_reset_n,
    input wire logic io_converter_enable,
    input wire logic memory_rail_enable,
    input wire logic pll_ldo_enable,
    input wire logic sram_ldo_enable,
    input wire logic pll_sram_ldo_enable,
    input wire logic sim_ldo_enable,
    input wire logic core_forced_pwm_sel,
    input wire logic sleep_select_n,
    input wire logic vin_above_uvlo,
    input wire logic vin_above_2v4,
    input wire logic keepalive_above_2v3,
    input wire logic keepalive_above_2v425,
    input wire logic io_rail_in_reg,
    input wire logic backup_powered,
    input wire logic dead_batt_cmp,
    input wire logic low_batt_cmp,
    output logic [4:0] core_vsel,
    output logic core_pwm_forced,
    output logic pll_rail_on,
    output logic sram_rail_on,
    output logic sim_rail_on,
    output logic [1:0] sim_level,
    output logic io_converter_on,
    output logic io_sleep_ldo_on,
    output logic mem_converter_on,
    output logic mem_sleep_ldo_on,
    output logic keepalive_from_io,
    output logic keepalive_from_backup,
    output logic device_enabled,
    output logic serial_active,
    output logic reset_out_n_o,
    output logic reset_out_n_oe,
    output logic dead_batt_flag_n_o,
    output logic dead_batt_flag_n_oe,
    output logic low_batt_flag_n_o,
    output logic low_batt_flag_n_oe
);

    localparam int unsigned SYN_W = 17;

    logic [SYN_W-1:0] pin_raw;
    logic [SYN_W-1:0] pin_s;
    logic mr_n_s, io_en_s, mem_en_s, pll_en_s, sram_en_s, pll_sram_en_s, sim_en_s;
    logic pwm_sel_s, sleep_n_s, vin_ok_s, vin_2v4_s, ka_2v3_s, ka_2v425_s;
    logic io_reg_s, backup_battery_in_s, dead_s, low_s;

    // every pin is asynchronous to hclk
    assign pin_raw = {low_batt_cmp, dead_batt_cmp, backup_powered, io_rail_in_reg,
                      keepalive_above_2v425, keepalive_above_2v3, vin_above_2v4,
                      vin_above_uvlo, sleep_select_n, core_forced_pwm_sel, sim_ldo_enable,
                      pll_sram_ldo_enable, sram_ldo_enable, pll_ldo_enable,
                      memory_rail_enable, io_converter_enable, manual_reset_n};

    pmr_sync #(
        .W(SYN_W)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    assign {low_s, dead_s, backup_battery_in_s, io_reg_s, ka_2v425_s, ka_2v3_s, vin_2v4_s, vin_ok_s,
            sleep_n_s, pwm_sel_s, sim_en_s, pll_sram_en_s, sram_en_s, pll_en_s,
            mem_en_s, io_en_s, mr_n_s} = pin_s;

    // registers
    logic [4:0] core_vsel_r;
    logic [1:0] sim_level_r;
    logic [7:0] serial_byte_r;
    logic combined_r;
    logic hreadyout_r, hresp_r;
    logic [31:0] hrdata_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic dev_on_r, serial_r;
    logic pll_r, sram_r, sim_r, pwm_r;
    logic io_conv_r, io_ldo_r, mem_conv_r, mem_ldo_r, ka_io_r, ka_bk_r;
    logic rso_oe_r, dbo_oe_r, lbo_oe_r;
    logic vin_2v4_d_r;

    logic addr_ok, rd_req, wr_now, any_en, rst_hold, timer_pwr, released;
    logic wr_core, wr_sim, wr_ser;
    logic [31:0] rd_mux;
    logic [31:0] status_w;

    // bus address phase, whole-word writes only
    assign addr_ok = hsel && htrans[1] && hready;
    assign rd_req = addr_ok && !hwrite;
    assign wr_now = wr_pend_r && serial_r;
    assign wr_core = wr_now && wr_addr_r == `PMR_ADDR_CORE_VSEL;
    assign wr_sim = wr_now && wr_addr_r == `PMR_ADDR_SIM_LEVEL;
    assign wr_ser = wr_now && wr_addr_r == `PMR_ADDR_SERIAL_BYTE;

    // any regulator enable asserted
    assign any_en = io_en_s || mem_en_s || pll_en_s || sram_en_s || pll_sram_en_s || sim_en_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok && hwrite && hsize == 3'h2;
            wr_addr_r <= haddr[7:0];
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b0;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    assign status_w = {24'h000000, vin_ok_s, backup_battery_in_s, low_s, dead_s, ka_io_r,
                       dev_on_r, serial_r, !released};

    always_comb begin
        unique case (haddr[7:0])
            `PMR_ADDR_CORE_VSEL: rd_mux = {27'h0000000, core_vsel_r};
            `PMR_ADDR_SIM_LEVEL: rd_mux = {30'h00000000, sim_level_r};
            `PMR_ADDR_SERIAL_BYTE: rd_mux = {24'h000000, serial_byte_r};
            `PMR_ADDR_CTRL: rd_mux = {31'h00000000, combined_r};
            `PMR_ADDR_STATUS: rd_mux = status_w;
            default: rd_mux = 32'h00000000; // unmapped reads zero
        endcase
    end

    // read data captured at the address phase, held through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (rd_req) begin
            hrdata_r <= rd_mux;
        end
    end

    // core code: any 5-bit value legal; manual reset wins over a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_vsel_r <= `PMR_CORE_VSEL_RST;
        end else if (!mr_n_s) begin
            core_vsel_r <= `PMR_CORE_VSEL_RST;
        end else if (wr_core) begin
            core_vsel_r <= hwdata[4:0];
        end else if (wr_ser && !hwdata[`PMR_SER_SIM_SEL_BIT]) begin
            core_vsel_r <= hwdata[4:0];
        end
    end

    // sim level; undervoltage lockout does not clear it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sim_level_r <= `PMR_SIM_LEVEL_RST;
        end else if (wr_sim) begin
            sim_level_r <= hwdata[1:0];
        end else if (wr_ser && hwdata[`PMR_SER_SIM_SEL_BIT]) begin
            sim_level_r <= hwdata[1:0];
        end
    end

    // last serial byte kept for readback
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_byte_r <= 8'h00;
        end else if (wr_ser) begin
            serial_byte_r <= hwdata[7:0];
        end
    end

    // variant select; written any time so a fresh chip can be configured
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            combined_r <= `PMR_CTRL_RST;
        end else if (wr_pend_r && wr_addr_r == `PMR_ADDR_CTRL) begin
            combined_r <= hwdata[`PMR_CTRL_COMBINED_BIT];
        end
    end

    // lockout and serial gate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dev_on_r <= 1'b0;
            serial_r <= 1'b0;
        end else begin
            dev_on_r <= vin_ok_s;
            serial_r <= vin_ok_s && any_en;
        end
    end

    // regulator enables; lockout forces everything off and ignores pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_r <= 1'b0;
            sram_r <= 1'b0;
            sim_r <= 1'b0;
            pwm_r <= 1'b0;
        end else begin
            pll_r <= vin_ok_s && (combined_r ? pll_sram_en_s : pll_en_s);
            sram_r <= vin_ok_s && (combined_r ? pll_sram_en_s : sram_en_s);
            sim_r <= vin_ok_s && sim_en_s;
            pwm_r <= vin_ok_s && pwm_sel_s;
        end
    end

    // sleep select steers io and memory enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_conv_r <= 1'b0;
            io_ldo_r <= 1'b0;
            mem_conv_r <= 1'b0;
            mem_ldo_r <= 1'b0;
        end else begin
            io_conv_r <= vin_ok_s && io_en_s && sleep_n_s;
            io_ldo_r <= vin_ok_s && io_en_s && !sleep_n_s;
            mem_conv_r <= vin_ok_s && mem_en_s && sleep_n_s;
            mem_ldo_r <= vin_ok_s && mem_en_s && !sleep_n_s;
        end
    end

    // keepalive source; the two switches never close together
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ka_io_r <= 1'b0;
            ka_bk_r <= 1'b1;
        end else begin
            ka_io_r <= vin_ok_s && io_en_s && io_reg_s;
            ka_bk_r <= !(vin_ok_s && io_en_s && io_reg_s);
        end
    end

    // reset decision looks at keepalive only, never other rails
    assign rst_hold = !mr_n_s || !ka_2v425_s || !ka_2v3_s;
    // timer is dead while the input is below 2.4V, or in the first cycle that the input is above it
    assign timer_pwr = vin_2v4_s && vin_2v4_d_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vin_2v4_d_r <= 1'b0;
        end else begin
            vin_2v4_d_r <= vin_2v4_s;
        end
    end

    pmr_rst_timer #(
        .DELAY_CYC(RST_DELAY_CYC)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .hold(rst_hold),
        .timer_powered(timer_pwr),
        .released(released)
    );

    // open-drain pins: drive low only while backup battery is powered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rso_oe_r <= 1'b0;
            dbo_oe_r <= 1'b0;
            lbo_oe_r <= 1'b0;
        end else begin
            rso_oe_r <= backup_battery_in_s && !released;
            dbo_oe_r <= backup_battery_in_s && dead_s;
            lbo_oe_r <= backup_battery_in_s && low_s;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign core_vsel = core_vsel_r;
    assign core_pwm_forced = pwm_r;
    assign pll_rail_on = pll_r;
    assign sram_rail_on = sram_r;
    assign sim_rail_on = sim_r;
    assign sim_level = sim_level_r;
    assign io_converter_on = io_conv_r;
    assign io_sleep_ldo_on = io_ldo_r;
    assign mem_converter_on = mem_conv_r;
    assign mem_sleep_ldo_on = mem_ldo_r;
    assign keepalive_from_io = ka_io_r;
    assign keepalive_from_backup = ka_bk_r;
    assign device_enabled = dev_on_r;
    assign serial_active = serial_r;
    // open-drain data is a constant low
    assign reset_out_n_o = 1'b0;
    assign dead_batt_flag_n_o = 1'b0;
    assign low_batt_flag_n_o = 1'b0;
    assign reset_out_n_oe = rso_oe_r;
    assign dead_batt_flag_n_oe = dbo_oe_r;
    assign low_batt_flag_n_oe = lbo_oe_r;

    AST_MR_RESTORES_CORE: assert property (@(posedge hclk) disable iff (!hresetn)
        !mr_n_s |=> core_vsel_r == `PMR_CORE_VSEL_RST)
        else $error("manual reset did not restore core code");
    AST_SERIAL_CORE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_ser && mr_n_s && !hwdata[5]) |=> core_vsel_r == $past(hwdata[4:0]))
        else $error("serial byte did not program core code");
    AST_SIM_ONLY_BY_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(sim_level_r) |-> $past(wr_sim || (wr_ser && hwdata[5])))
        else $error("sim level changed without a write");
    AST_NO_WRITE_WHEN_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_r && !serial_r && mr_n_s) |=> $stable(core_vsel_r) && $stable(sim_level_r))
        else $error("setting changed while serial interface off");
    AST_LOCKOUT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !vin_ok_s |=> !pll_r && !sram_r && !sim_r && !io_conv_r && !io_ldo_r && !dev_on_r)
        else $error("rail enabled during lockout");
    AST_COMBINED: assert property (@(posedge hclk) disable iff (!hresetn)
        (combined_r && vin_ok_s) |=> pll_r == $past(pll_sram_en_s) && sram_r == pll_r)
        else $error("combined enable not followed by both rails");
    AST_SEPARATE: assert property (@(posedge hclk) disable iff (!hresetn)
        (!combined_r && vin_ok_s) |=> pll_r == $past(pll_en_s) && sram_r == $past(sram_en_s))
        else $error("separate enables not followed");
    AST_SLEEP_STEER: assert property (@(posedge hclk) disable iff (!hresetn)
        (vin_ok_s && io_en_s && !sleep_n_s) |=> io_ldo_r && !io_conv_r)
        else $error("sleep select did not pick sleep regulator");
    AST_KEEPALIVE_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ka_io_r != ka_bk_r)
        else $error("keepalive switches not exclusive");
    AST_RESET_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (rst_hold && backup_battery_in_s) ##1 backup_battery_in_s |=> rso_oe_r)
        else $error("reset not driven during reset condition");
    AST_RESET_IMMEDIATE: assert property (@(posedge hclk) disable iff (!hresetn)
        ($fell(rst_hold) && !timer_pwr && backup_battery_in_s) ##1 (!rst_hold && backup_battery_in_s) |=> !rso_oe_r)
        else $error("unpowered timer did not release at once");
    AST_RESET_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
        !backup_battery_in_s |=> !rso_oe_r && !dbo_oe_r && !lbo_oe_r)
        else $error("open-drain pin driven without backup battery");
    AST_DEAD_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_battery_in_s && dead_s) |=> dbo_oe_r)
        else $error("dead battery flag missing");
    AST_LOW_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        (backup_battery_in_s && low_s) |=> lbo_oe_r)
        else $error("low battery flag missing");

    CVR_MR_PRESS: cover property (@(posedge hclk) disable iff (!hresetn) $fell(mr_n_s));
    CVR_SIM_WRITE: cover property (@(posedge hclk) disable iff (!hresetn) wr_sim);
    CVR_RELEASE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(released));
    CVR_SLEEP: cover property (@(posedge hclk) disable iff (!hresetn) io_ldo_r);

endmodule

// ==== pmr_defines.svh ====
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

// register byte offsets
`define PMR_ADDR_CORE_VSEL 8'h00
`define PMR_ADDR_SIM_LEVEL 8'h04
`define PMR_ADDR_SERIAL_BYTE 8'h08
`define PMR_ADDR_CTRL 8'h0C
`define PMR_ADDR_STATUS 8'h10

// core_rail code: 0.700V + 25mV per step, 1.300V after reset
`define PMR_CORE_VSEL_W 5
`define PMR_CORE_VSEL_RST 5'h18
`define PMR_SIM_LEVEL_RST 2'h0
`define PMR_CTRL_RST 1'h0

// serial byte and ctrl register fields
`define PMR_SER_SIM_SEL_BIT 5
`define PMR_CTRL_COMBINED_BIT 0

// status bit positions
`define PMR_STAT_RESET_ACTIVE 0
`define PMR_STAT_SERIAL_ACTIVE 1
`define PMR_STAT_DEVICE_ON 2
`define PMR_STAT_KEEP_FROM_IO 3
`define PMR_STAT_DEAD_BATT 4
`define PMR_STAT_LOW_BATT 5
`define PMR_STAT_BACKUP_OK 6
`define PMR_STAT_VIN_OK 7

// timing
`define PMR_CLK_PERIOD_NS 5
`define PMR_RST_DELAY_NS 65000000

`endif

// ==== pmr_pkg.sv ====
package pmr_pkg;

    // reset release timer states
    typedef enum logic [2:0] {
        PMR_TMR_HOLD = 3'b001,
        PMR_TMR_DELAY = 3'b010,
        PMR_TMR_DONE = 3'b100
    } pmr_tmr_state_t;

    // sim_rail levels: 0V, 1.8V, 2.5V, 3.0V
    typedef enum logic [1:0] {
        PMR_SIM_0V0 = 2'h0,
        PMR_SIM_1V8 = 2'h1,
        PMR_SIM_2V5 = 2'h2,
        PMR_SIM_3V0 = 2'h3
    } pmr_sim_level_t;

endpackage

// ==== pmr_sync.sv ====
`timescale 1ns/1ps
module pmr_sync #(
    parameter int unsigned W = 17
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // two stages per bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= async_in[i];
                    sync_r <= meta_r;
                end
            end
            assign sync_out[i] = sync_r;
        end
    endgenerate

endmodule

// ==== pmr_rst_timer.sv ====
`timescale 1ns/1ps
module pmr_rst_timer import pmr_pkg::*; #(
    parameter int unsigned DELAY_CYC = 13000000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hold,
    input wire logic timer_powered,
    output logic released
);

    localparam logic [23:0] LAST_CNT = 24'(DELAY_CYC - 1);

    pmr_tmr_state_t state_r;
    logic [23:0] cnt_r;

    // hold restarts the delay at any point; unpowered timer releases at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= PMR_TMR_HOLD;
        end else begin
            unique case (state_r)
                PMR_TMR_HOLD: begin
                    if (!hold) begin
                        state_r <= timer_powered ? PMR_TMR_DELAY : PMR_TMR_DONE;
                    end
                end
                PMR_TMR_DELAY: begin
                    if (hold) begin
                        state_r <= PMR_TMR_HOLD;
                    end else if (cnt_r == LAST_CNT) begin
                        state_r <= PMR_TMR_DONE;
                    end
                end
                PMR_TMR_DONE: begin
                    if (hold) begin
                        state_r <= PMR_TMR_HOLD;
                    end
                end
            endcase
        end
    end

    // delay counter, cleared whenever not counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 24'h000000;
        end else if (state_r == PMR_TMR_DELAY && !hold) begin
            cnt_r <= cnt_r + 24'h000001;
        end else begin
            cnt_r <= 24'h000000;
        end
    end

    assign released = (state_r == PMR_TMR_DONE);

    AST_DELAY_EXPIRES: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == PMR_TMR_DELAY && !hold && cnt_r == LAST_CNT) |=> released)
        else $error("release timer did not expire on its last count");
    AST_NO_EARLY_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(released) && $past(state_r) == PMR_TMR_DELAY) |-> $past(cnt_r) == LAST_CNT)
        else $error("reset released before the full delay");

endmodule

// ==== pmr_host_model.sv ====
`timescale 1ns/1ps
// host side: two enable groups, a variant select and a manual reset request
module pmr_host_model (
    input wire logic hclk,
    input wire logic sys_on,
    input wire logic pwr_on,
    input wire logic combo,
    input wire logic mr_req,
    output logic io_converter_enable = 1'b0,
    output logic memory_rail_enable = 1'b0,
    output logic sim_ldo_enable = 1'b0,
    output logic pll_ldo_enable = 1'b0,
    output logic sram_ldo_enable = 1'b0,
    output logic pll_sram_ldo_enable = 1'b0,
    output logic manual_reset_n = 1'b1
);
    // pins move just after an edge, like a host gpio write
    always @(posedge hclk) begin
        io_converter_enable <= sys_on;
        memory_rail_enable <= sys_on;
        sim_ldo_enable <= sys_on;
        pll_ldo_enable <= pwr_on && !combo;
        sram_ldo_enable <= pwr_on && !combo;
        pll_sram_ldo_enable <= pwr_on && combo;
        manual_reset_n <= !mr_req;
    end
endmodule

// ==== tb_pmic_reset_rail_control.sv ====
`timescale 1ns/1ps
module tb_pmic_reset_rail_control;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic sys_on = 1'b1, pwr_on = 1'b1, combo = 1'b0, mr_req = 1'b0;
    logic manual_reset_n, io_converter_enable, memory_rail_enable, pll_ldo_enable;
    logic sram_ldo_enable, pll_sram_ldo_enable, sim_ldo_enable, core_forced_pwm_sel = 1'b0;
    logic sleep_select_n = 1'b1, vin_above_uvlo = 1'b1, vin_above_2v4 = 1'b1;
    logic keepalive_above_2v3 = 1'b1, keepalive_above_2v425 = 1'b1, io_rail_in_reg = 1'b1;
    logic backup_powered = 1'b1, dead_batt_cmp = 1'b0, low_batt_cmp = 1'b0;
    logic [4:0] core_vsel;
    logic [1:0] sim_level;
    logic core_pwm_forced, pll_rail_on, sram_rail_on, sim_rail_on, io_converter_on;
    logic io_sleep_ldo_on, mem_converter_on, mem_sleep_ldo_on, keepalive_from_io;
    logic keepalive_from_backup, device_enabled, serial_active, reset_out_n_o, reset_out_n_oe;
    logic dead_batt_flag_n_o, dead_batt_flag_n_oe, low_batt_flag_n_o, low_batt_flag_n_oe;
    int err_count = 0, cmp_count = 0;
    // open-drain pins with pull-ups
    wire reset_out_n = reset_out_n_oe ? reset_out_n_o : 1'b1;
    wire dead_flag = dead_batt_flag_n_oe ? dead_batt_flag_n_o : 1'b1;
    wire low_flag = low_batt_flag_n_oe ? low_batt_flag_n_o : 1'b1;

    pmr_top #(.RST_DELAY_CYC(20)) u_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .manual_reset_n, .io_converter_enable, .memory_rail_enable, .pll_ldo_enable,
        .sram_ldo_enable, .pll_sram_ldo_enable, .sim_ldo_enable, .core_forced_pwm_sel,
        .sleep_select_n, .vin_above_uvlo, .vin_above_2v4, .keepalive_above_2v3,
        .keepalive_above_2v425, .io_rail_in_reg, .backup_powered, .dead_batt_cmp,
        .low_batt_cmp, .core_vsel, .core_pwm_forced, .pll_rail_on, .sram_rail_on,
        .sim_rail_on, .sim_level, .io_converter_on, .io_sleep_ldo_on, .mem_converter_on,
        .mem_sleep_ldo_on, .keepalive_from_io, .keepalive_from_backup, .device_enabled,
        .serial_active, .reset_out_n_o, .reset_out_n_oe, .dead_batt_flag_n_o,
        .dead_batt_flag_n_oe, .low_batt_flag_n_o, .low_batt_flag_n_oe);

    pmr_host_model u_host (.hclk, .sys_on, .pwr_on, .combo, .mr_req, .io_converter_enable,
        .memory_rail_enable, .sim_ldo_enable, .pll_ldo_enable, .sram_ldo_enable,
        .pll_sram_ldo_enable, .manual_reset_n);

    // 200 MHz clock
    initial begin
        forever #2.5 hclk = ~hclk;
    end

    task automatic final_report();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // bounded wait for hready, a stuck slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer; read data taken at the data phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    // gap of one cycle so the readback sees a settled register
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        cyc(1);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // reset release is timed, so the wait is bounded a little past it
    task automatic wait_rel(input int lim);
        int n;
        n = 0;
        while (reset_out_n !== 1'b1) begin
            n++;
            if (n > lim) begin
                err_count++;
                final_report();
            end
            @(posedge hclk);
        end
        chk(reset_out_n, 1'b1);
    endtask

    // main sequence
    initial begin
        cyc(3);
        hresetn <= 1'b1;
        cyc(2);
        chk(core_vsel, 5'h18);
        rdchk(8'h04, 32'h0);
        rdchk(8'h20, 32'h0);
        cyc(40);
        chk(reset_out_n, 1'b1);
        chk({pll_rail_on, sram_rail_on, sim_rail_on}, 3'h7);
        chk({serial_active, device_enabled, keepalive_from_io}, 3'h7);
        chk({io_converter_on, io_sleep_ldo_on, mem_converter_on, core_pwm_forced}, 4'hA);
        rdchk(8'h10, 32'hCE);
        bus(1'b1, 8'h00, 32'h1F);
        rdchk(8'h00, 32'h1F);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h08, 32'h20 | i);
            cyc(1);
            chk(sim_level, i);
        end
        bus(1'b1, 8'h08, 32'h05);
        cyc(1);
        chk(core_vsel, 5'h05);
        rdchk(8'h08, 32'h05);
        bus(1'b1, 8'h0C, 32'h1);
        combo <= 1'b1;
        cyc(6);
        chk({pll_rail_on, sram_rail_on}, 2'h3);
        pwr_on <= 1'b0;
        sys_on <= 1'b0;
        cyc(6);
        chk({pll_rail_on, sram_rail_on, serial_active}, 3'h0);
        chk({keepalive_from_backup, reset_out_n}, 2'h3);
        bus(1'b1, 8'h00, 32'h02);
        rdchk(8'h00, 32'h05);
        sys_on <= 1'b1;
        sleep_select_n <= 1'b0;
        core_forced_pwm_sel <= 1'b1;
        cyc(6);
        chk({io_sleep_ldo_on, io_converter_on, mem_sleep_ldo_on}, 3'h5);
        chk({core_pwm_forced, device_enabled}, 2'h3);
        // lockout turns off pwm, device, sleep ldo and serial gate but keeps the stored settings
        vin_above_uvlo <= 1'b0;
        cyc(6);
        chk({core_pwm_forced, device_enabled, io_sleep_ldo_on, serial_active}, 4'h0);
        bus(1'b1, 8'h00, 32'h09);
        vin_above_uvlo <= 1'b1;
        rdchk(8'h00, 32'h05);
        mr_req <= 1'b1;
        cyc(6);
        chk({reset_out_n, core_vsel}, 6'h18);
        mr_req <= 1'b0;
        cyc(10);
        mr_req <= 1'b1;
        cyc(2);
        mr_req <= 1'b0;
        cyc(18);
        chk(reset_out_n, 1'b0);
        wait_rel(20);
        vin_above_2v4 <= 1'b0;
        keepalive_above_2v425 <= 1'b0;
        cyc(6);
        chk(reset_out_n, 1'b0);
        keepalive_above_2v425 <= 1'b1;
        cyc(8);
        chk(reset_out_n, 1'b1);
        backup_powered <= 1'b0;
        mr_req <= 1'b1;
        dead_batt_cmp <= 1'b1;
        cyc(6);
        chk({reset_out_n_oe, dead_batt_flag_n_oe, low_batt_flag_n_oe}, 3'h0);
        backup_powered <= 1'b1;
        low_batt_cmp <= 1'b1;
        cyc(6);
        chk({dead_flag, low_flag, reset_out_n}, 3'h0);
        final_report();
    end
endmodule
